// File: include/sarc_pkg.sv
// sarc_pkg: constants and types of the standby and reset control
package sarc_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RST_MIN_NS = 10000;
  localparam int unsigned RST_CYCLES =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] RST_CNT = 11'(RST_CYCLES);
  localparam int unsigned TICK_NS = 64000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned WDOG_MS = 340;
  localparam int unsigned WDOG_CYCLES_DEF =
    WDOG_MS * 1000000 / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  localparam logic [3:0] OP_TIMER = 4'h2;
  localparam logic [3:0] OP_ANY = 4'h8;
  localparam logic [3:0] SP_OVER = 4'h6;
  localparam logic [3:0] SP_UNDER = 4'h7;
  localparam logic [1:0] VEC_TIMER = 2'h3;
  localparam logic [1:0] VEC_PIN = 2'h2;
  localparam logic [1:0] VEC_ITV = 2'h1;
  localparam logic [1:0] CAUSE_PIN = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;
  localparam logic [1:0] CAUSE_STACK = 2'h3;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] DBUF_RST = 16'h0320;
  localparam logic [7:0] TMATCH_RST = 8'hff;
  localparam logic [5:0] INMASK_RST = 6'h3f;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] REG_TMATCH = 4'h0;
  localparam logic [3:0] REG_TCOUNT = 4'h1;
  localparam logic [3:0] REG_WDOG = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_DBUF = 4'h4;
  localparam logic [3:0] REG_PORTCFG = 4'h5;
  localparam logic [3:0] REG_LATCH = 4'h6;
  localparam logic [3:0] REG_WIN = 4'h7;
  localparam logic [3:0] REG_CHI = 4'h8;
  localparam logic [3:0] REG_CLO = 4'h9;
  localparam int unsigned WDOG_KICK_BIT = 3;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_HALT = 5'h02,
    ST_STOP = 5'h04,
    ST_WAIT = 5'h08,
    ST_RESET = 5'h10
  } sarc_state_t;
  typedef struct packed {
    logic [3:0] wake_port_a;
    logic [3:0] wake_port_b;
    logic [3:0] wake_port_c;
    logic [3:0] wake_port_d;
  } sarc_ports_t;
  typedef struct packed {
    logic timer_request_flag;
    logic interval_request_flag;
    logic pin_event_flag;
    logic timer_request_enable;
    logic interval_request_enable;
    logic pin_event_enable;
    logic global_enable;
  } sarc_irq_t;
  typedef struct packed {
    logic req;
    logic stop;
    logic [3:0] op;
  } sarc_cmd_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } sarc_bus_t;
  typedef struct packed {
    sarc_state_t state;
    logic op_any;
    logic from_reset;
    logic pull;
    logic [1:0] cause;
    logic [10:0] rcnt;
    logic [15:0] pcnt;
    logic [7:0] tcnt;
    logic [7:0] tmatch;
    logic [31:0] wcnt;
    logic [15:0] dbuf;
    logic [5:0] inmask;
    logic [11:0] latch;
    logic [3:0] win;
    logic [7:0] chi;
    logic [7:0] clo;
    logic [15:0] rdata;
    logic resume;
    logic vector;
    logic [1:0] vsel;
    logic tf_clr;
    logic tf_set;
    logic itv_restart;
  } sarc_regs_t;
  localparam sarc_regs_t REGS_RST = '{
    state: ST_RESET, dbuf: DBUF_RST, tmatch: TMATCH_RST,
    inmask: INMASK_RST, from_reset: 1'b1, default: '0};
endpackage

// File: core/sarc_core.sv
// sarc_core: standby, wake and reset sequencing
//
// Chosen here: the register offsets and the strobed register port.
module sarc_core
  import sarc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned WDOG_CYCLES = WDOG_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire sarc_bus_t bus,
  output logic [15:0] rdata,
  input wire sarc_cmd_t cmd,
  input wire sarc_ports_t ports,
  input wire sarc_irq_t irq,
  input wire logic [3:0] stack_pointer,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  output logic cpu_run,
  output logic osc_enable,
  output logic core_reset,
  output logic resume_pulse,
  output logic vector_pulse,
  output logic [1:0] vector_sel,
  output logic timer_flag_clear,
  output logic timer_flag_set,
  output logic interval_restart,
  output logic [5:0] port_in_cfg,
  output logic [11:0] port_latch,
  output logic [15:0] data_buffer
);
  // ------------------------------------------------------------
  // wake and entry terms
  // ------------------------------------------------------------
  sarc_regs_t s;
  sarc_regs_t n;
  logic [11:0] bcd_mask;
  logic pins_low;
  logic en_irq;
  logic pin_req;
  logic tick;
  logic pin_long;
  logic wdog_to;
  logic sp_bad;

  assign bcd_mask = {{4{s.inmask[5]}}, {4{s.inmask[4]}}, s.inmask[3:0]};
  assign pins_low = (|(~ports.wake_port_a)) |
    (|(~{ports.wake_port_d, ports.wake_port_c, ports.wake_port_b}
      & bcd_mask));
  assign pin_req = irq.pin_event_flag & irq.pin_event_enable;
  assign en_irq = (irq.timer_request_flag & irq.timer_request_enable) |
    (irq.interval_request_flag & irq.interval_request_enable) | pin_req;
  assign tick = s.pcnt == 16'(TICK_CYCLES - 1);
  assign pin_long = s.state != ST_RESET && !rst_pin_in &&
    s.rcnt == RST_CNT;
  assign wdog_to = s.state != ST_STOP && s.state != ST_RESET &&
    s.wcnt == 32'(WDOG_CYCLES - 1);
  assign sp_bad = s.state == ST_RUN &&
    (stack_pointer == SP_OVER || stack_pointer == SP_UNDER);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = s;
    n.resume = 1'b0;
    n.vector = 1'b0;
    n.tf_clr = 1'b0;
    n.tf_set = 1'b0;
    n.itv_restart = 1'b0;
    n.rdata = '0;
    // watchdog runs except in stop and reset
    if (s.state != ST_STOP && s.state != ST_RESET) begin
      n.wcnt = s.wcnt + 32'h0000_0001;
    end
    // reset pin low-time filter
    if (s.state != ST_RESET) begin
      if (rst_pin_in) begin
        n.rcnt = '0;
      end else if (s.rcnt != RST_CNT) begin
        n.rcnt = s.rcnt + 11'h001;
      end
    end
    // register reads
    if (bus.rd) begin
      case (bus.addr)
        REG_TMATCH: n.rdata = {8'h00, s.tmatch};
        REG_TCOUNT: n.rdata = {8'h00, s.tcnt};
        REG_STATUS: n.rdata = {9'h000, s.cause, s.state};
        REG_DBUF: n.rdata = s.dbuf;
        REG_PORTCFG: n.rdata = {10'h000, s.inmask};
        REG_LATCH: n.rdata = {4'h0, s.latch};
        REG_WIN: n.rdata = {12'h000, s.win};
        REG_CHI: n.rdata = {8'h00, s.chi};
        REG_CLO: n.rdata = {8'h00, s.clo};
        default: n.rdata = '0;
      endcase
    end
    // register writes, ignored while held in reset
    if (bus.wr && s.state != ST_RESET) begin
      case (bus.addr)
        REG_TMATCH: n.tmatch = bus.wdata[7:0];
        REG_WDOG: begin
          if (bus.wdata[WDOG_KICK_BIT]) begin
            n.wcnt = '0;
          end
        end
        REG_DBUF: n.dbuf = bus.wdata;
        REG_PORTCFG: n.inmask = bus.wdata[5:0];
        REG_LATCH: n.latch = bus.wdata[11:0];
        REG_WIN: n.win = bus.wdata[3:0];
        REG_CHI: n.chi = bus.wdata[7:0];
        REG_CLO: n.clo = bus.wdata[7:0];
        default: ;
      endcase
    end
    // reset sources take priority over everything
    if (pin_long || wdog_to || sp_bad) begin
      n.state = ST_RESET;
      n.pull = !pin_long;
      n.cause = pin_long ? CAUSE_PIN :
        (wdog_to ? CAUSE_WDOG : CAUSE_STACK);
      n.rcnt = '0;
      n.from_reset = 1'b1;
      n.dbuf = DBUF_RST;
      n.tmatch = TMATCH_RST;
      n.tcnt = '0;
      n.inmask = INMASK_RST;
      n.latch = '0;
      n.wcnt = '0;
      n.pcnt = '0;
      if (s.state == ST_RUN) begin
        n.win = '0;
        n.chi = '0;
        n.clo = '0;
      end
    end else begin
      case (s.state)
        ST_RUN: begin
          if (cmd.req && !cmd.stop && cmd.op == OP_TIMER &&
              !irq.timer_request_flag) begin
            n.state = ST_HALT;
            n.op_any = 1'b0;
          end else if (cmd.req && !cmd.stop && cmd.op == OP_ANY &&
              !en_irq && !pins_low) begin
            n.state = ST_HALT;
            n.op_any = 1'b1;
          end else if (cmd.req && cmd.stop && cmd.op == OP_ANY &&
              !pins_low && !pin_req) begin
            n.state = ST_STOP;
          end
        end
        ST_HALT: begin
          if (!s.op_any) begin
            if (irq.timer_request_flag) begin
              n.state = ST_RUN;
              if (irq.global_enable && irq.timer_request_enable) begin
                n.vector = 1'b1;
                n.vsel = VEC_TIMER;
              end else begin
                n.resume = 1'b1;
              end
            end
          end else if (en_irq && irq.global_enable) begin
            n.state = ST_RUN;
            n.vector = 1'b1;
            if (irq.timer_request_flag && irq.timer_request_enable) begin
              n.vsel = VEC_TIMER;
            end else if (pin_req) begin
              n.vsel = VEC_PIN;
            end else begin
              n.vsel = VEC_ITV;
            end
          end else if (en_irq || pins_low) begin
            n.state = ST_RUN;
            n.resume = 1'b1;
          end
        end
        ST_STOP: begin
          if (pins_low || pin_req) begin
            n.state = ST_WAIT;
            n.tf_clr = 1'b1;
            n.itv_restart = 1'b1;
            n.tcnt = '0;
            n.pcnt = '0;
            n.from_reset = 1'b0;
          end
        end
        ST_WAIT: begin
          if (tick) begin
            n.pcnt = '0;
            if (s.tcnt == s.tmatch) begin
              n.state = ST_RUN;
              n.tf_set = !s.from_reset;
              n.resume = !s.from_reset;
              n.from_reset = 1'b0;
            end else begin
              n.tcnt = s.tcnt + 8'h01;
            end
          end else begin
            n.pcnt = s.pcnt + 16'h0001;
          end
        end
        ST_RESET: begin
          if (s.pull) begin
            n.rcnt = s.rcnt + 11'h001;
            if (s.rcnt == RST_CNT) begin
              n.pull = 1'b0;
              n.rcnt = '0;
            end
          end else if (rst_pin_in) begin
            n.state = ST_WAIT;
            n.tcnt = '0;
            n.pcnt = '0;
          end
        end
        default: n.state = ST_RESET;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= REGS_RST;
    end else if (clk_en) begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata = s.rdata;
  assign cpu_run = s.state == ST_RUN;
  assign osc_enable = s.state != ST_STOP && s.state != ST_RESET;
  assign core_reset = s.state == ST_RESET ||
    (s.state == ST_WAIT && s.from_reset);
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = !(s.state == ST_RESET && s.pull);
  assign resume_pulse = s.resume;
  assign vector_pulse = s.vector;
  assign vector_sel = s.vsel;
  assign timer_flag_clear = s.tf_clr;
  assign timer_flag_set = s.tf_set;
  assign interval_restart = s.itv_restart;
  assign port_in_cfg = s.inmask;
  assign port_latch = s.latch;
  assign data_buffer = s.dbuf;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_halt_clock_runs: assert property (s.state == ST_HALT |->
    !cpu_run && osc_enable) else $error("halt state wrong");
  a_stop_osc_off: assert property (s.state == ST_STOP |->
    !cpu_run && !osc_enable) else $error("stop state wrong");
  a_timer_halt_wake: assert property (clk_en && s.state == ST_HALT &&
    !s.op_any && irq.timer_request_flag && !pin_long && !wdog_to |=>
    s.state == ST_RUN && (resume_pulse || vector_pulse))
    else $error("timer halt did not wake");
  a_timer_halt_hold: assert property (clk_en && s.state == ST_HALT &&
    !s.op_any && !irq.timer_request_flag && !pin_long && !wdog_to |=>
    s.state == ST_HALT) else $error("timer halt woke early");
  a_timer_vector: assert property (clk_en && s.state == ST_HALT &&
    !s.op_any && irq.timer_request_flag && irq.timer_request_enable &&
    irq.global_enable && !pin_long && !wdog_to |=>
    vector_pulse && vector_sel == VEC_TIMER)
    else $error("timer halt did not vector");
  a_halt_masked: assert property (clk_en && s.state == ST_HALT &&
    s.op_any && !en_irq && !pins_low && !pin_long && !wdog_to |=>
    s.state == ST_HALT) else $error("masked request woke halt");
  a_pin_halt_resume: assert property (clk_en && s.state == ST_HALT &&
    s.op_any && pins_low && !en_irq && !pin_long && !wdog_to |=>
    resume_pulse && !vector_pulse) else $error("pin wake did not resume");
  a_enabled_vector: assert property (clk_en && s.state == ST_HALT &&
    s.op_any && en_irq && irq.global_enable && !pin_long && !wdog_to |=>
    s.state == ST_RUN && vector_pulse)
    else $error("enabled request did not vector");
  a_enabled_resume: assert property (clk_en && s.state == ST_HALT &&
    s.op_any && en_irq && !irq.global_enable && !pin_long && !wdog_to |=>
    resume_pulse && !vector_pulse)
    else $error("request without global enable did not resume");
  a_halt_nop: assert property (clk_en && s.state == ST_RUN &&
    cmd.req && !cmd.stop && cmd.op == OP_TIMER && irq.timer_request_flag &&
    !pin_long && !wdog_to && !sp_bad |=> s.state == ST_RUN)
    else $error("halt entered with flag set");
  a_any_halt_nop: assert property (clk_en && s.state == ST_RUN &&
    cmd.req && !cmd.stop && cmd.op == OP_ANY && (en_irq || pins_low) &&
    !pin_long && !wdog_to && !sp_bad |=> s.state == ST_RUN)
    else $error("halt entered with wake pending");
  a_bad_operand: assert property (clk_en && s.state == ST_RUN &&
    cmd.req && cmd.op != OP_ANY && (cmd.stop || cmd.op != OP_TIMER) &&
    !pin_long && !wdog_to && !sp_bad |=> s.state == ST_RUN)
    else $error("prohibited operand entered standby");
  a_stop_nop: assert property (clk_en && s.state == ST_RUN && cmd.req &&
    cmd.stop && pins_low && !pin_long && !wdog_to && !sp_bad |=>
    s.state == ST_RUN) else $error("stop entered with pin low");
  a_stop_release: assert property (clk_en && s.state == ST_STOP &&
    (pins_low || pin_req) && !pin_long |=> s.state == ST_WAIT &&
    timer_flag_clear && interval_restart && s.tcnt == 8'h00)
    else $error("stop release wrong");
  a_wait_bound: assert property (s.state == ST_WAIT |->
    s.tcnt <= s.tmatch) else $error("wait count passed match");
  a_wait_end: assert property (clk_en && s.state == ST_WAIT && tick &&
    s.tcnt == s.tmatch && !pin_long && !wdog_to |=>
    s.state == ST_RUN ##1 s.state != ST_WAIT)
    else $error("wait did not end on match");
  a_wait_resume: assert property (clk_en && s.state == ST_WAIT &&
    tick && s.tcnt == s.tmatch && !s.from_reset && !pin_long && !wdog_to |=>
    timer_flag_set && resume_pulse) else $error("stop wait end wrong");
  a_reset_wait_end: assert property (clk_en && s.state == ST_WAIT &&
    tick && s.tcnt == s.tmatch && s.from_reset && !pin_long &&
    !wdog_to |=> cpu_run && !core_reset && !resume_pulse)
    else $error("reset wait end wrong");
  a_reset_exit: assert property (clk_en && s.state == ST_RESET &&
    !s.pull && rst_pin_in |=> s.state == ST_WAIT && osc_enable &&
    core_reset) else $error("reset release wrong");
  a_pin_reset: assert property (clk_en && s.state != ST_RESET &&
    !rst_pin_in && s.rcnt == RST_CNT |=> core_reset && !osc_enable &&
    data_buffer == DBUF_RST && port_in_cfg == INMASK_RST)
    else $error("reset pin ignored");
  a_stack_reset: assert property (clk_en && sp_bad |=>
    s.state == ST_RESET && !rst_pin_oe_n)
    else $error("stack fault ignored");
  a_wdog_reset: assert property (clk_en && wdog_to |=>
    core_reset && s.wcnt == 32'h0)
    else $error("watchdog timeout ignored");
  a_run_reset_clears: assert property (clk_en && s.state == ST_RUN &&
    (sp_bad || wdog_to) |=> s.win == 4'h0 && s.chi == 8'h00 &&
    s.clo == 8'h00) else $error("run reset kept registers");
  a_retain_standby: assert property (clk_en && s.state == ST_HALT &&
    pin_long |=> s.win == $past(s.win) && s.chi == $past(s.chi))
    else $error("standby reset lost registers");

  c_halt_vector: cover property (s.state == ST_HALT ##1 vector_pulse);
  c_stop_wake: cover property (s.state == ST_STOP ##1 s.state == ST_WAIT);
  c_wait_done: cover property (s.state == ST_WAIT ##1 resume_pulse);
  c_wdog_reset: cover property (wdog_to ##1 !rst_pin_oe_n);
  c_any_resume: cover property (s.state == ST_HALT && s.op_any ##1
    resume_pulse);
endmodule

// File: tb/sarc_pins_model.sv
// sarc_pins_model: wake port pins and reset pin outside the device
module sarc_pins_model
  import sarc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_pin_oe_n,
  output sarc_ports_t ports,
  output logic rst_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  logic press = 1'b0;
  initial ports = '1;
  // reset wire has a pull-up; button or device pulls it low
  assign rst_pin_in = ~(press | (rst_pin_oe_n === 1'b0));
  task automatic pin_low(input int unsigned idx);
    @(posedge sys_clk);
    ports <= sarc_ports_t'(~(16'h0001 << idx));
  endtask
  task automatic pins_high();
    @(posedge sys_clk);
    ports <= '1;
  endtask
  task automatic hold_reset(input logic on);
    @(posedge sys_clk);
    press <= on;
  endtask
endmodule

// File: tb/sarc_core_tb.sv
// sarc_core_tb: self-checking bench of the standby and reset control
module sarc_core_tb
  import sarc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int unsigned TICK = 4;
  localparam int unsigned WDOG = 3000;
  localparam int unsigned WAIT_CYC = 256 * TICK;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  sarc_bus_t bus = '0;
  sarc_cmd_t cmd = '0;
  sarc_irq_t irq = '0;
  logic [3:0] sp = 4'h3;
  sarc_ports_t ports;
  logic rst_pin_in, rst_pin_out, rst_pin_oe_n, cpu_run, osc_enable;
  logic core_reset, resume_pulse, vector_pulse;
  logic timer_flag_clear, timer_flag_set, interval_restart;
  logic [1:0] vector_sel;
  logic [5:0] port_in_cfg;
  logic [11:0] port_latch;
  logic [15:0] rdata, data_buffer;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  logic [1:0] vec [3] = '{VEC_TIMER, VEC_ITV, VEC_PIN};
  always #4 sys_clk = ~sys_clk;
  sarc_core #(.TICK_CYCLES(TICK), .WDOG_CYCLES(WDOG)) sarc_core_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .cmd(cmd), .ports(ports), .irq(irq),
    .stack_pointer(sp), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
    .cpu_run(cpu_run), .osc_enable(osc_enable), .core_reset(core_reset),
    .resume_pulse(resume_pulse), .vector_pulse(vector_pulse),
    .vector_sel(vector_sel), .timer_flag_clear(timer_flag_clear),
    .timer_flag_set(timer_flag_set), .interval_restart(interval_restart),
    .port_in_cfg(port_in_cfg), .port_latch(port_latch),
    .data_buffer(data_buffer));
  sarc_pins_model sarc_pins_model_i (
    .sys_clk(sys_clk), .rst_pin_oe_n(rst_pin_oe_n), .ports(ports),
    .rst_pin_in(rst_pin_in));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic set_irq(input logic [6:0] v);
    @(posedge sys_clk);
    irq <= sarc_irq_t'(v);
  endtask
  task automatic std(input logic s, input logic [3:0] op);
    wr(REG_WDOG, 16'h0008);
    @(posedge sys_clk);
    cmd <= '{req: 1'b1, stop: s, op: op};
    @(posedge sys_clk);
    cmd.req <= 1'b0;
    #1;
  endtask
  task automatic wait_for(input int w, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
      case (w)
        0: hit = cpu_run;
        1: hit = resume_pulse | vector_pulse;
        2: hit = timer_flag_clear;
        3: hit = ~rst_pin_oe_n;
        default: hit = core_reset;
      endcase
    end while (hit !== 1'b1 && cnt < lim);
    if (hit !== 1'b1) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic wait_run();
    wait_for(0, WAIT_CYC + 2000, n);
    chk1(core_reset, 1'b0);
    wr(REG_WDOG, 16'h0008);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk1(osc_enable, 1'b0);
    chk1(core_reset, 1'b1);
    chk(data_buffer, DBUF_RST);
    chk({4'h0, port_latch}, 16'h0000);
    chk({10'h000, port_in_cfg}, 16'h003f);
    @(posedge sys_clk);
    #1 chk1(osc_enable, 1'b1);
    chk1(core_reset, 1'b1);
    rd_chk(REG_TMATCH, 16'h00ff);
    wait_for(0, WAIT_CYC + 100, n);
    chk1(n >= WAIT_CYC - 6 && n <= WAIT_CYC + 2, 1'b1);
    wr(REG_WDOG, 16'h0008);
    wr(REG_WIN, 16'h0005);
    rd_chk(REG_WIN, 16'h0005);
    rd_chk(4'hf, 16'h0000);
    rd_chk(REG_STATUS, 16'h0001);
    // no-op entries: flag set, bad operands
    set_irq(7'h40);
    std(1'b0, OP_TIMER);
    chk1(cpu_run, 1'b1);
    set_irq(7'h00);
    std(1'b0, 4'h5);
    chk1(cpu_run, 1'b1);
    std(1'b1, 4'h2);
    chk1(cpu_run, 1'b1);
    // timer halt: only the timer request wakes
    std(1'b0, OP_TIMER);
    chk1(cpu_run, 1'b0);
    chk1(osc_enable, 1'b1);
    rd_chk(REG_STATUS, 16'h0002);
    sarc_pins_model_i.pin_low(0);
    set_irq(7'h25);
    repeat (4) @(posedge sys_clk);
    #1 chk1(cpu_run, 1'b0);
    sarc_pins_model_i.pins_high();
    set_irq(7'h40);
    wait_for(1, 10, n);
    chk1(resume_pulse, 1'b1);
    chk1(vector_pulse, 1'b0);
    set_irq(7'h09);
    std(1'b0, OP_TIMER);
    set_irq(7'h49);
    wait_for(1, 10, n);
    chk1(vector_pulse, 1'b1);
    chk({14'h0000, vector_sel}, {14'h0000, VEC_TIMER});
    // any-wake halt: each request source
    for (int k = 0; k < 3; k++) begin
      set_irq(7'h01 | (7'h08 >> k));
      std(1'b0, OP_ANY);
      chk1(cpu_run, 1'b0);
      set_irq(7'h01 | (7'h40 >> k));
      repeat (4) @(posedge sys_clk);
      #1 chk1(cpu_run, 1'b0);
      set_irq(7'h01 | (7'h40 >> k) | (7'h08 >> k));
      wait_for(1, 10, n);
      chk1(vector_pulse, 1'b1);
      chk({14'h0000, vector_sel}, {14'h0000, vec[k]});
      set_irq(7'h00);
    end
    set_irq(7'h04);
    std(1'b0, OP_ANY);
    set_irq(7'h24);
    wait_for(1, 10, n);
    chk1(resume_pulse, 1'b1);
    set_irq(7'h0f);
    for (int k = 0; k < 4; k++) begin
      std(1'b0, OP_ANY);
      sarc_pins_model_i.pin_low(k * 5);
      wait_for(1, 10, n);
      chk1(resume_pulse, 1'b1);
      chk1(vector_pulse, 1'b0);
      sarc_pins_model_i.pins_high();
    end
    sarc_pins_model_i.pin_low(8);
    std(1'b0, OP_ANY);
    chk1(cpu_run, 1'b1);
    sarc_pins_model_i.pins_high();
    set_irq(7'h24);
    std(1'b0, OP_ANY);
    chk1(cpu_run, 1'b1);
    // stop: entry checks, pin wake, settle count
    wr(REG_TMATCH, 16'h0003);
    rd_chk(REG_TMATCH, 16'h0003);
    set_irq(7'h12);
    std(1'b1, OP_ANY);
    chk1(cpu_run, 1'b1);
    set_irq(7'h00);
    std(1'b1, OP_ANY);
    chk1(osc_enable, 1'b0);
    rd_chk(REG_STATUS, 16'h0004);
    sarc_pins_model_i.pin_low(4);
    wait_for(2, 10, n);
    chk1(interval_restart, 1'b1);
    wait_for(1, 100, n);
    chk(16'(n), 16'(4 * TICK));
    chk1(timer_flag_set, 1'b1);
    sarc_pins_model_i.pins_high();
    set_irq(7'h02);
    std(1'b1, OP_ANY);
    set_irq(7'h12);
    wait_for(2, 10, n);
    chk1(osc_enable, 1'b1);
    wait_for(1, 100, n);
    set_irq(7'h00);
    // stack codes force reset from run
    for (int k = 6; k < 8; k++) begin
      wr(REG_DBUF, 16'h1234);
      wr(REG_LATCH, 16'h0abc);
      wr(REG_PORTCFG, 16'h0000);
      @(posedge sys_clk);
      sp <= 4'(k);
      wait_for(3, 10, n);
      chk1(core_reset, 1'b1);
      chk1(rst_pin_out, 1'b0);
      @(posedge sys_clk);
      sp <= 4'h3;
      rd_chk(REG_STATUS, 16'h0070);
      chk(data_buffer, DBUF_RST);
      chk({4'h0, port_latch}, 16'h0000);
      chk({10'h000, port_in_cfg}, 16'h003f);
      wait_run();
      rd_chk(REG_WIN, 16'h0000);
    end
    // reset pin during halt keeps the window
    wr(REG_WIN, 16'h0009);
    std(1'b0, OP_TIMER);
    sarc_pins_model_i.hold_reset(1'b1);
    repeat (1240) @(posedge sys_clk);
    #1 chk1(core_reset, 1'b0);
    wait_for(4, 30, n);
    rd_chk(REG_STATUS, 16'h0030);
    rd_chk(REG_TCOUNT, 16'h0000);
    sarc_pins_model_i.hold_reset(1'b0);
    wait_run();
    rd_chk(REG_WIN, 16'h0009);
    // watchdog left alone
    wait_for(3, WDOG + 100, n);
    chk1(n >= WDOG - 20 && n <= WDOG + 20, 1'b1);
    rd_chk(REG_STATUS, 16'h0050);
    wait_run();
    finish_test();
  end
endmodule
